/* core/aewr_pkg.sv */
// Purpose: Shared types and constants for the access error write-back report.
// Assumes: One core clock, active-low asynchronous reset.
// Notes: Field codes are the encodings carried in the frame's status slots.
package aewr_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // Transfer type codes
    localparam logic [1:0] TT_NORMAL = 2'h0;
    localparam logic [1:0] TT_BLOCK_MOVE = 2'h1;
    // Transfer modifier that marks a cache push
    localparam logic [2:0] TM_PUSH = 3'h0;
    // Size code for a full line
    localparam logic [1:0] SIZE_LINE = 2'h3;
    localparam logic [1:0] SIZE_LONG = 2'h0;

    // Reset values
    localparam logic [ADDR_W-1:0] FA_RESET = 32'h0000_0000;

    // One write-back status slot
    typedef struct packed {
        logic valid;
        logic [1:0] tt;
        logic [2:0] tm;
        logic [1:0] size;
    } aewr_slot_s;

    localparam aewr_slot_s SLOT_RESET = '{valid: 1'b0, tt: 2'h0, tm: 3'h0,
                                          size: 2'h0};

    // Fault kind seen by the capture logic
    typedef enum logic [2:0] {
        FK_NONE = 3'b000,
        FK_READ = 3'b001,
        FK_PUSH = 3'b010,
        FK_WRITE = 3'b011,
        FK_BLOCK_WRITE = 3'b100,
        FK_PAGE = 3'b101
    } aewr_kind_e;

    // Fault as presented by the data memory stage
    typedef struct packed {
        logic read;
        logic [1:0] tt;
        logic [2:0] tm;
        logic [1:0] size;
        logic page_fault;
        logic [ADDR_W-1:0] logical_addr;
        logic [ADDR_W-1:0] physical_addr;
    } aewr_fault_s;

    // Frame fields handed to the exception sequencer
    typedef struct packed {
        logic fault_read_indicator;
        logic fault_push_indicator;
        aewr_slot_s writeback_one_status;
        aewr_slot_s writeback_two_status;
        aewr_slot_s writeback_three_status;
        logic [ADDR_W-1:0] fault_address_field;
        logic [2:0] kind;
    } aewr_frame_s;

endpackage : aewr_pkg

/* core/aewr_report.sv */
// Purpose: Fill the write-back status slots and fault address of the
//          access error frame when an access fault is taken.
// Assumes: Pending slot states come from the write-back pipeline on i_clk.
// Notes: The frame is snapshotted once per fault and held until the next.
//        Every output is a flip-flop; the frame decode in front of it is
//        purely combinational from the inputs sampled with the take.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// How it works
// - Read faults report slots one and two as not valid.
// - Read faults may still report slot three as a valid pending write.
// - Hold the data memory stage until the faulting read data is returned.
// - Push faults always report slot one valid bit cleared.
// - Push bus errors give physical fault address; all others logical.
// - No write posted while block move ahead (stall rises one cycle after it); slot two move excludes three.
// - Valid slot two with block-move flag marks data not to be written.
// - Pending slot two block move is reported only if its read hit cache.
// - Every slot carries valid and transfer type; type 01 means block move.
// - Push fault is transfer type 00 with transfer modifier 000.
// - Slot three never reports block move nor full line size.
module aewr_report
    import aewr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_fault_take,
    input wire aewr_fault_s i_fault,
    input wire aewr_slot_s i_wb1_pending,
    input wire aewr_slot_s i_wb2_pending,
    input wire aewr_slot_s i_wb3_pending,
    input wire logic i_wb2_move_read_hit,
    input wire logic i_block_move_ahead,
    input wire logic i_read_returned,
    output logic o_frame_valid,
    output aewr_frame_s o_frame,
    output logic o_slot_two_block_move_flag,
    output logic o_dmem_hold,
    output logic o_post_stall
);

    ////////////////////////////////////////////////////////////////////////
    // Classification helpers

    // Push is recognised by code alone, independent of direction
    function automatic logic is_push(input logic [1:0] tt,
                                     input logic [2:0] tm);
        is_push = (tt == TT_NORMAL) && (tm == TM_PUSH);
    endfunction : is_push

    // A slot holds a block move only while its valid bit is set
    function automatic logic is_block_move(input aewr_slot_s s);
        is_block_move = s.valid && (s.tt == TT_BLOCK_MOVE);
    endfunction : is_block_move

    // Next values of the frame, built from the fault and the pending slots;
    // nothing here is stored until the take edge
    aewr_kind_e kind_d;
    aewr_frame_s frame_d;
    aewr_slot_s wb1_d;
    aewr_slot_s wb2_d;
    aewr_slot_s wb3_d;
    logic push_now;
    logic move2_ok;

    // Decide the fault kind from the faulting access. A read wins over
    // every other code: it ties up the data memory stage, so it can be
    // neither a push nor a page fault at the same time
    always_comb begin
        push_now = is_push(i_fault.tt, i_fault.tm);
        if (i_fault.read) begin
            kind_d = FK_READ;
        end else if (push_now) begin
            kind_d = FK_PUSH;
        end else if (i_fault.page_fault) begin
            kind_d = FK_PAGE;
        end else if (i_fault.tt == TT_BLOCK_MOVE) begin
            kind_d = FK_BLOCK_WRITE;
        end else begin
            kind_d = FK_WRITE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot one: only a faulted normal or block-move write owns it
    always_comb begin
        wb1_d = i_wb1_pending;
        case (kind_d)
            FK_READ: begin
                // The read holds the data memory stage: nothing pends here
                wb1_d.valid = 1'b0;
            end
            FK_PUSH: begin
                // A push frame never shows slot one as valid
                wb1_d.valid = 1'b0;
            end
            FK_PAGE: begin
                // The faulted write itself sits in slot two, not slot one
                wb1_d.valid = 1'b0;
            end
            default: begin
                // Faulted normal or block-move write is slot one
                wb1_d.valid = 1'b1;
                wb1_d.tt = i_fault.tt;
                wb1_d.tm = i_fault.tm;
                wb1_d.size = i_fault.size;
            end
        endcase
    end

    // Slot two: empty behind a faulting read; a block move whose read
    // missed the cache is never reported as pending
    always_comb begin
        wb2_d = i_wb2_pending;
        move2_ok = !is_block_move(i_wb2_pending) || i_wb2_move_read_hit;
        if (!move2_ok) begin
            // Restarting a missed move would touch a peripheral twice
            wb2_d.valid = 1'b0;
        end
        if (kind_d == FK_READ) begin
            wb2_d.valid = 1'b0;
        end
    end

    // Slot three: kept on a read, but never a block move or a full line
    always_comb begin
        // A read may leave a deferred or later write pending here
        wb3_d = i_wb3_pending;
        if (wb3_d.tt == TT_BLOCK_MOVE || wb3_d.size == SIZE_LINE) begin
            wb3_d.valid = 1'b0;
            wb3_d.tt = TT_NORMAL;
            wb3_d.size = SIZE_LONG;
        end
        // No write is posted behind a move still ahead of the integer unit
        if (is_block_move(wb2_d)) begin
            wb3_d.valid = 1'b0;
        end
    end

    // Frame assembly; only a push bus error reports a physical address
    always_comb begin
        frame_d.fault_read_indicator = i_fault.read;
        // The push flag follows the decoded kind, so a read wins over it
        frame_d.fault_push_indicator = (kind_d == FK_PUSH);
        frame_d.writeback_one_status = wb1_d;
        frame_d.writeback_two_status = wb2_d;
        frame_d.writeback_three_status = wb3_d;
        if (kind_d == FK_PUSH) begin
            frame_d.fault_address_field = i_fault.physical_addr;
        end else begin
            frame_d.fault_address_field = i_fault.logical_addr;
        end
        frame_d.kind = kind_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Atomic frame capture: every field loads on the same edge
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_frame <= '{fault_read_indicator: 1'b0,
                         fault_push_indicator: 1'b0,
                         writeback_one_status: SLOT_RESET,
                         writeback_two_status: SLOT_RESET,
                         writeback_three_status: SLOT_RESET,
                         fault_address_field: FA_RESET,
                         kind: FK_NONE};
        end else if (i_fault_take) begin
            o_frame <= frame_d;
        end
    end

    // Handler skips slot two data when this flag is set; it loads on the
    // same edge as the frame so the two can never disagree
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_slot_two_block_move_flag <= 1'b0;
        end else if (i_fault_take) begin
            o_slot_two_block_move_flag <= is_block_move(wb2_d);
        end
    end

    // Frame valid pulses on the capture edge itself, so the
    // sequencer sees the pulse and the new frame in the same cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_frame_valid <= 1'b0;
        end else begin
            o_frame_valid <= i_fault_take;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data memory stage hold during a faulting read; a new read fault
    // wins over a return in the same cycle so the hold is never lost.
    // A return with no read outstanding is harmless: the hold is low
    // already and simply stays there
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dmem_hold <= 1'b0;
        end else if (i_fault_take && i_fault.read) begin
            o_dmem_hold <= 1'b1;
        end else if (i_read_returned) begin
            o_dmem_hold <= 1'b0;
        end
    end

    // Execution stage may not post a write while a block move is ahead.
    // Registered, so the stall trails the move by one cycle: the pipeline
    // must raise its ahead signal one cycle before a write could slip
    // past the move
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_post_stall <= 1'b0;
        end else begin
            o_post_stall <= i_block_move_ahead;
        end
    end

endmodule : aewr_report

`default_nettype wire

/* tb/aewr_report_props.sv */
// Purpose: Port-level checks on the access error frame capture.
// Assumes: One clock, reset active low.
// Notes: Bound into the report block below its endmodule.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module aewr_report_props
    import aewr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_fault_take,
    input wire aewr_fault_s i_fault,
    input wire aewr_slot_s i_wb2_pending,
    input wire logic i_wb2_move_read_hit,
    input wire logic i_block_move_ahead,
    input wire logic i_read_returned,
    input wire logic o_frame_valid,
    input wire aewr_frame_s o_frame,
    input wire logic o_slot_two_block_move_flag,
    input wire logic o_dmem_hold,
    input wire logic o_post_stall
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Frame slots, addresses and flags against the fault that was taken
    a_read_slots_clear: assert property (i_fault_take && i_fault.read |=>
        !o_frame.writeback_one_status.valid
        && !o_frame.writeback_two_status.valid) else $error("read slots");
    a_push_one_clear: assert property (o_frame.fault_push_indicator
        |-> !o_frame.writeback_one_status.valid) else $error("push slot");
    a_push_phys_addr: assert property (i_fault_take && !i_fault.read
        && i_fault.tt == TT_NORMAL && i_fault.tm == TM_PUSH
        |=> o_frame.fault_address_field == $past(i_fault.physical_addr))
        else $error("push address");
    a_move_excl_three: assert property (o_slot_two_block_move_flag
        |-> !o_frame.writeback_three_status.valid) else $error("slot three");
    a_three_no_move: assert property (o_frame.writeback_three_status.tt !=
        TT_BLOCK_MOVE && o_frame.writeback_three_status.size != SIZE_LINE)
        else $error("slot three kind");
    a_move_miss_drop: assert property (i_fault_take && i_wb2_pending.valid
        && i_wb2_pending.tt == TT_BLOCK_MOVE && !i_wb2_move_read_hit
        |=> !o_frame.writeback_two_status.valid) else $error("move miss");
    a_hold_read_set: assert property (i_fault_take && i_fault.read
        |=> o_dmem_hold) else $error("hold set");
    a_hold_keep_clear: assert property (o_dmem_hold && !i_read_returned
        |=> o_dmem_hold) else $error("hold dropped");
    a_frame_one_pulse: assert property (i_fault_take |=> o_frame_valid
        ##1 (o_frame_valid == $past(i_fault_take))) else $error("pulse");
    a_post_stall_lag: assert property (i_block_move_ahead |=> o_post_stall)
        else $error("post stall");
    c_push: cover property (i_fault_take && !i_fault.read && i_fault.tm == 3'h0);
    c_read_three: cover property (o_frame_valid
        && o_frame.fault_read_indicator
        && o_frame.writeback_three_status.valid);
    c_move: cover property (o_slot_two_block_move_flag);
    c_hold: cover property (o_dmem_hold ##1 !o_dmem_hold);
endmodule : aewr_report_props
bind aewr_report aewr_report_props u_props (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_fault_take(i_fault_take), .i_fault(i_fault),
    .i_wb2_pending(i_wb2_pending), .i_wb2_move_read_hit(i_wb2_move_read_hit),
    .i_block_move_ahead(i_block_move_ahead),
    .i_read_returned(i_read_returned), .o_frame_valid(o_frame_valid),
    .o_frame(o_frame), .o_slot_two_block_move_flag(o_slot_two_block_move_flag),
    .o_dmem_hold(o_dmem_hold), .o_post_stall(o_post_stall));
`default_nettype wire

/* tb/aewr_report_tb_top.sv */
// Purpose: Random fault capture compared with a bench model each cycle.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes: Takes come back to back at random, so overwrite is exercised.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module aewr_report_tb_top;
    import aewr_pkg::*;
    logic clk = 0, rst_n = 0, tk = 0, hit = 0, bma = 0, ret = 0;
    aewr_fault_s fi = '0;
    aewr_slot_s w1 = '0, w2 = '0, w3 = '0;
    aewr_frame_s fr;
    logic fv, flag, hold, pst, hm, ps, push, rd, v1, v2, v3, mv, etk;
    logic [38:0] ef;
    logic [95:0] r;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, k;
    aewr_report dut (.i_clk(clk), .i_reset_n(rst_n), .i_fault_take(tk),
        .i_fault(fi), .i_wb1_pending(w1), .i_wb2_pending(w2),
        .i_wb3_pending(w3), .i_wb2_move_read_hit(hit),
        .i_block_move_ahead(bma), .i_read_returned(ret), .o_frame_valid(fv),
        .o_frame(fr), .o_slot_two_block_move_flag(flag), .o_dmem_hold(hold),
        .o_post_stall(pst));
    // Clock and hang guard; a hung run still ends in the one verdict
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic check(string n, logic [63:0] s, logic [63:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // Model what each edge should capture, then compare once it has landed
    initial begin
        hm = 0;
        repeat (2) @(posedge clk);
        #2 rst_n = 1;
        void'($urandom(98));
        repeat (1500) begin
            @(posedge clk);
            rd = fi.read;
            push = !rd && fi.tt == TT_NORMAL && fi.tm == TM_PUSH;
            v2 = !rd && w2.valid && !(w2.tt == TT_BLOCK_MOVE && !hit);
            mv = v2 && w2.tt == TT_BLOCK_MOVE;
            v3 = w3.valid && w3.tt != TT_BLOCK_MOVE && w3.size != SIZE_LINE
                && !mv;
            v1 = !(rd || push || fi.page_fault);
            k = rd ? 1 : push ? 2 : fi.page_fault ? 5
                : fi.tt == TT_BLOCK_MOVE ? 4 : 3;
            ef = {k[2:0], push ? fi.physical_addr : fi.logical_addr,
                v1, v2, v3, mv};
            hm = (tk && rd) ? 1'b1 : ret ? 1'b0 : hm;
            ps = bma;
            etk = tk;
            #2;
            check("frame_valid", 64'(fv), 64'(etk));
            if (etk) check("frame", 64'({fr.kind, fr.fault_address_field,
                fr.writeback_one_status.valid, fr.writeback_two_status.valid,
                fr.writeback_three_status.valid, flag}), 64'(ef));
            check("hold", 64'(hold), 64'(hm));
            check("post_stall", 64'(pst), 64'(ps));
            // Push codes made common so every fault kind shows up often
            r = {$urandom, $urandom, $urandom};
            fi = r[72:0];
            if (r[73]) fi.tm = TM_PUSH;
            {w1, w2, w3} = r[95:72];
            {tk, hit, bma} = 3'($urandom);
            ret = $urandom % 4 == 0;
        end
        // Reset in mid-run clears every output at once; a read taken on
        // the first edge after release must land straight away
        @(posedge clk);
        #2 rst_n = 0;
        fi.read = 1;
        tk = 1;
        #1;
        check("reset_frame", 64'(fr), 64'h0);
        check("reset_outs", 64'({fv, flag, hold, pst}), 64'h0);
        @(posedge clk);
        #2 rst_n = 1;
        @(posedge clk);
        #2;
        check("restart", 64'({fv, fr.kind, hold,
            fr.writeback_one_status.valid, fr.writeback_two_status.valid}),
            64'({1'h1, FK_READ, 1'h1, 2'h0}));
        complete_run();
    end
endmodule : aewr_report_tb_top
`default_nettype wire
